// >>> ufc_defines.vh
// Purpose: constants shared by the fifo control block
// Assumes: 32-bit ahb-lite register bus, byte addresses
// Notes: offsets are byte addresses of aligned words
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

// ********************************
// register map
// ********************************
`define UFC_OFS_CTRL 8'h00
`define UFC_OFS_COUNT 8'h04
`define UFC_OFS_TXDATA 8'h08
`define UFC_OFS_RXDATA 8'h0c
`define UFC_OFS_IRQ_STAT 8'h10
`define UFC_OFS_IRQ_CLR 8'h14
`define UFC_OFS_IRQ_EN 8'h18
`define UFC_OFS_BAUD 8'h1c

// ********************************
// field positions and reset values
// ********************************
`define UFC_CTRL_RESET 8'h00
`define UFC_BIT_LOOP 0
`define UFC_BIT_RXCLR 1
`define UFC_BIT_TXCLR 2
`define UFC_BIT_MCE 3
`define UFC_TTRG_LSB 4
`define UFC_RTRG_LSB 6
`define UFC_BAUD_RESET 11'h000
`define UFC_BAUD_EXT 10
`define UFC_IRQ_RXFULL 0
`define UFC_IRQ_TXLOW 1

// ********************************
// thresholds and timing
// ********************************
`define UFC_RTRG_00 5'h01
`define UFC_RTRG_01 5'h04
`define UFC_RTRG_10 5'h08
`define UFC_RTRG_11 5'h0e
`define UFC_TTRG_00 5'h08
`define UFC_TTRG_01 5'h04
`define UFC_TTRG_10 5'h02
`define UFC_TTRG_11 5'h01
`define UFC_RTS_LEVEL 5'h0f
`define UFC_OVERSAMPLE 4'hf
`define UFC_HALF_BIT 4'h7
`define UFC_FRAME_BITS 4'h9
`define UFC_DATA_BITS 4'h8

`endif

// >>> ufc_fifo_control.v
// Purpose: fifo control, fill counts and a minimal 8n1 engine of a serial port
// Assumes: single clk domain, rst_n async low, ahb-lite slave with zero wait
// Notes: standby input acts like a synchronous reset of fifos and control
//
// What this block does
// - rx flag when count exceeds selected threshold
// - tx flag when unsent count below threshold
// - modem disabled: cts seen low, rts zero
// - tx clear bit empties transmit fifo
// - rx clear bit empties receive fifo
// - reset or standby empties both fifos
// - loop bit routes tx into rx
// - control register zero on reset, standby
// - control register always readable, writable except while standby holds it at zero
// - tx count in bits 12 to 8
// - rx count in bits 4 to 0
// - count register read-only, resets to zero
// - prescale 0 divisor 0 gives clk/32
// - sixteen-entry byte fifo each direction
`include "ufc_defines.vh"

module ufc_fifo_control #(
  parameter DEPTH_LOG2 = 4
) (
  input wire clk,
  input wire rst_n,
  input wire standby,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg txd,
  input wire rxd,
  input wire cts_n,
  output wire rts_n,
  input wire sck_in,
  output wire irq
);

  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam [4:0] FULL_COUNT = DEPTH;
  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;

  // ********************************
  // helpers
  // ********************************
  // receive trigger decode
  function [4:0] rx_thr;
    input [1:0] sel;
    rx_thr = sel[1] ? (sel[0] ? `UFC_RTRG_11 : `UFC_RTRG_10)
                    : (sel[0] ? `UFC_RTRG_01 : `UFC_RTRG_00);
  endfunction
  // transmit trigger decode
  function [4:0] tx_thr;
    input [1:0] sel;
    tx_thr = sel[1] ? (sel[0] ? `UFC_TTRG_11 : `UFC_TTRG_10)
                    : (sel[0] ? `UFC_TTRG_01 : `UFC_TTRG_00);
  endfunction

  // ********************************
  // registers and state
  // ********************************
  reg [7:0] fifo_control_reg;
  reg [10:0] baud_reg;
  reg [1:0] irq_stat;
  reg [1:0] irq_en;
  reg [7:0] tx_mem [0:DEPTH-1];
  reg [7:0] rx_mem [0:DEPTH-1];
  reg [DEPTH_LOG2-1:0] tx_rd, tx_wr, rx_rd, rx_wr;
  reg [4:0] tx_count_field, rx_count_field;
  reg ph_write, ph_valid;
  reg [7:0] ph_addr;
  reg rxd_s1, rxd_s2, cts_s1, cts_s2, sck_s1, sck_s2, sck_s3;
  reg [15:0] div_cnt;
  reg tx_state;
  reg [9:0] tx_shift;
  reg [3:0] tx_sub, tx_bits;
  reg rx_busy;
  reg [3:0] rx_sub, rx_bits;
  reg [7:0] rx_shift;
  wire loop_on = fifo_control_reg[`UFC_BIT_LOOP];
  wire modem_ctl_enable = fifo_control_reg[`UFC_BIT_MCE];
  wire tx_clr = fifo_control_reg[`UFC_BIT_TXCLR] | standby;
  wire rx_clr = fifo_control_reg[`UFC_BIT_RXCLR] | standby;
  wire [4:0] rx_trig = rx_thr(fifo_control_reg[`UFC_RTRG_LSB+1:`UFC_RTRG_LSB]);
  wire [4:0] tx_trig = tx_thr(fifo_control_reg[`UFC_TTRG_LSB+1:`UFC_TTRG_LSB]);
  wire rx_full_flag = rx_count_field > rx_trig;
  wire tx_low_flag = tx_count_field < tx_trig;

  // ********************************
  // bus slave
  // ********************************
  // zero wait state, always okay: standby locks out control and tx data writes
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire addr_ok = hsel & hready & htrans[1];
  wire rd_now = addr_ok & ~hwrite;
  wire [7:0] a_now = haddr[7:0];
  wire wr_do = ph_valid & ph_write;
  wire pop_rx = rd_now & (a_now == `UFC_OFS_RXDATA) & (rx_count_field != 5'h00) & ~rx_clr;
  wire push_tx = wr_do & (ph_addr == `UFC_OFS_TXDATA) & (tx_count_field != FULL_COUNT)
                 & ~tx_clr;
  // capture the address phase for the following data phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_valid <= addr_ok;
      ph_write <= hwrite;
      ph_addr <= a_now;
    end
  end
  // read data registered at the address phase so it stands in the data phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (rd_now) begin
      case (a_now)
        `UFC_OFS_CTRL: hrdata <= {24'h000000, fifo_control_reg};
        `UFC_OFS_COUNT: hrdata <= {19'h00000, tx_count_field, 3'h0, rx_count_field};
        `UFC_OFS_RXDATA: hrdata <= {24'h000000, pop_rx ? rx_mem[rx_rd] : 8'h00};
        `UFC_OFS_IRQ_STAT: hrdata <= {22'h000000, tx_low_flag, rx_full_flag, 6'h00, irq_stat};
        `UFC_OFS_IRQ_EN: hrdata <= {30'h00000000, irq_en};
        `UFC_OFS_BAUD: hrdata <= {21'h000000, baud_reg};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
  // control, baud and enable writes; standby forces control back to zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_control_reg <= `UFC_CTRL_RESET;
      baud_reg <= `UFC_BAUD_RESET;
      irq_en <= 2'b00;
    end else begin
      if (standby) begin
        fifo_control_reg <= `UFC_CTRL_RESET;
      end else if (wr_do && ph_addr == `UFC_OFS_CTRL) begin
        fifo_control_reg <= hwdata[7:0];
      end
      if (wr_do && ph_addr == `UFC_OFS_BAUD) begin
        baud_reg <= hwdata[10:0];
      end
      if (wr_do && ph_addr == `UFC_OFS_IRQ_EN) begin
        irq_en <= hwdata[1:0];
      end
    end
  end
  // sticky events; a level still present re-sets over a clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 2'b00;
    end else begin
      irq_stat[`UFC_IRQ_RXFULL] <= rx_full_flag | (irq_stat[`UFC_IRQ_RXFULL] &
        ~(wr_do && ph_addr == `UFC_OFS_IRQ_CLR && hwdata[`UFC_IRQ_RXFULL]));
      irq_stat[`UFC_IRQ_TXLOW] <= tx_low_flag | (irq_stat[`UFC_IRQ_TXLOW] &
        ~(wr_do && ph_addr == `UFC_OFS_IRQ_CLR && hwdata[`UFC_IRQ_TXLOW]));
    end
  end
  assign irq = |(irq_stat & irq_en);

  // ********************************
  // pin synchronisers
  // ********************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
    end else begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      cts_s1 <= cts_n;
      cts_s2 <= cts_s1;
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
    end
  end

  // modem lines: disabled means clear-to-send always and rts held at zero
  wire cts_seen_n = modem_ctl_enable ? cts_s2 : 1'b0;
  assign rts_n = modem_ctl_enable ? (rx_count_field >= `UFC_RTS_LEVEL) : 1'b0;
  // loopback: pin ignored, receiver sees our own transmit line
  wire rx_line = loop_on ? tx_shift[0] | (tx_state == TX_IDLE) : rxd_s2;

  // ********************************
  // oversample tick
  // ********************************
  // internal tick every 2*(N+1)*4^n clocks, so n=0 N=0 gives clk/32 per bit
  wire [15:0] div_end = ({8'h00, baud_reg[7:0]} + 16'h0001)
                        << ({baud_reg[9:8], 1'b0} + 3'h1);
  wire int_tick = (div_cnt >= div_end - 16'h0001);
  // external 16x clock: one tick per rising edge, needs sck_in <= clk/4
  wire ext_tick = sck_s2 & ~sck_s3;
  wire tick = baud_reg[`UFC_BAUD_EXT] ? ext_tick : int_tick;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
    end else if (int_tick || standby) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // ********************************
  // transmit fifo and engine
  // ********************************
  wire tx_start = (tx_state == TX_IDLE) & (tx_count_field != 5'h00) & ~cts_seen_n
                  & ~tx_clr & tick;
  always @(posedge clk) begin
    if (push_tx) begin
      tx_mem[tx_wr] <= hwdata[7:0];
    end
  end
  // pointers and counts; clear discards everything pending
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wr <= {DEPTH_LOG2{1'b0}};
      tx_rd <= {DEPTH_LOG2{1'b0}};
      tx_count_field <= 5'h00;
    end else if (tx_clr) begin
      tx_wr <= {DEPTH_LOG2{1'b0}};
      tx_rd <= {DEPTH_LOG2{1'b0}};
      tx_count_field <= 5'h00;
    end else begin
      if (push_tx) begin
        tx_wr <= tx_wr + 1'b1;
      end
      if (tx_start) begin
        tx_rd <= tx_rd + 1'b1;
      end
      tx_count_field <= tx_count_field + {4'h0, push_tx} - {4'h0, tx_start};
    end
  end

  // frame: start, eight data lsb first, stop; sixteen ticks per bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_shift <= 10'h3ff;
      tx_sub <= 4'h0;
      tx_bits <= 4'h0;
      txd <= 1'b1;
    end else begin
      txd <= loop_on ? 1'b1 : (tx_state == TX_IDLE) | tx_shift[0];
      case (tx_state)
        TX_IDLE: begin
          if (tx_start) begin
            tx_shift <= {1'b1, tx_mem[tx_rd], 1'b0};
            tx_sub <= 4'h0;
            tx_bits <= 4'h0;
            tx_state <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_clr) begin
            tx_state <= TX_IDLE;
            tx_shift <= 10'h3ff;
          end else if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == `UFC_OVERSAMPLE) begin
              tx_shift <= {1'b1, tx_shift[9:1]};
              tx_bits <= tx_bits + 4'h1;
              if (tx_bits == `UFC_FRAME_BITS) begin
                tx_state <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ********************************
  // receive engine and fifo
  // ********************************
  wire rx_done = rx_busy & tick & (rx_sub == `UFC_OVERSAMPLE)
                 & (rx_bits == `UFC_DATA_BITS);
  wire push_rx = rx_done & rx_line & (rx_count_field != FULL_COUNT) & ~rx_clr;
  // start seen low at mid bit, then sample each bit centre; bad stop drops it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_sub <= 4'h0;
      rx_bits <= 4'h0;
      rx_shift <= 8'h00;
    end else if (rx_clr) begin
      rx_busy <= 1'b0;
      rx_sub <= 4'h0;
    end else if (tick) begin
      if (!rx_busy) begin
        if (!rx_line) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == `UFC_HALF_BIT) begin
            rx_busy <= 1'b1;
            rx_sub <= 4'h0;
            rx_bits <= 4'h0;
          end
        end else begin
          rx_sub <= 4'h0;
        end
      end else begin
        rx_sub <= rx_sub + 4'h1;
        if (rx_sub == `UFC_OVERSAMPLE) begin
          rx_bits <= rx_bits + 4'h1;
          if (rx_bits == `UFC_DATA_BITS) begin
            rx_busy <= 1'b0;
          end else begin
            rx_shift <= {rx_line, rx_shift[7:1]};
          end
        end
      end
    end
  end

  always @(posedge clk) begin
    if (push_rx) begin
      rx_mem[rx_wr] <= rx_shift;
    end
  end

  // overrun: a byte arriving to a full fifo is lost
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wr <= {DEPTH_LOG2{1'b0}};
      rx_rd <= {DEPTH_LOG2{1'b0}};
      rx_count_field <= 5'h00;
    end else if (rx_clr) begin
      rx_wr <= {DEPTH_LOG2{1'b0}};
      rx_rd <= {DEPTH_LOG2{1'b0}};
      rx_count_field <= 5'h00;
    end else begin
      if (push_rx) begin
        rx_wr <= rx_wr + 1'b1;
      end
      if (pop_rx) begin
        rx_rd <= rx_rd + 1'b1;
      end
      rx_count_field <= rx_count_field + {4'h0, push_rx} - {4'h0, pop_rx};
    end
  end

endmodule // ufc_fifo_control

// >>> ufc_fifo_monitor.sv
// Purpose: port checker of the fifo control block
// Assumes: zero-wait bus, one clock domain
// Notes: shadows follow software writes seen on the bus
`include "ufc_defines.vh"
module ufc_fifo_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic standby,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic irq
);
  // ********************
  // bus shadows
  // ********************
  logic wp;
  logic [7:0] wa;
  logic [7:0] sh;
  logic [1:0] en;
  wire ap = hsel && hready && htrans[1];
  wire rp = ap && !hwrite;
  wire rc = rp && haddr[7:0] == `UFC_OFS_CTRL;
  wire rn = rp && haddr[7:0] == `UFC_OFS_COUNT;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // standby wins over a write landing on the same edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= 1'b0;
      wa <= 8'h00;
      sh <= `UFC_CTRL_RESET;
      en <= 2'h0;
    end else begin
      wp <= ap && hwrite;
      wa <= haddr[7:0];
      if (standby) begin
        sh <= `UFC_CTRL_RESET;
      end else if (wp && wa == `UFC_OFS_CTRL) begin
        sh <= hwdata[7:0];
      end
      if (wp && wa == `UFC_OFS_IRQ_EN) begin
        en <= hwdata[1:0];
      end
    end
  end
  bus_ok_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  modem_off_a: assert property (!sh[`UFC_BIT_MCE] |-> !rts_n)
    else $error("rts raised with modem off");
  loop_quiet_a: assert property (sh[`UFC_BIT_LOOP] && $past(sh[`UFC_BIT_LOOP]) |-> txd)
    else $error("txd moved in loopback");
  ctrl_read_a: assert property (rc && !wp && !standby |=> hrdata == {24'h0, sh})
    else $error("control read mismatch");
  count_pad_a: assert property (rn |=> hrdata[31:13] == 19'h0 && hrdata[7:5] == 3'h0)
    else $error("count padding not zero");
  count_max_a: assert property (rn |=> hrdata[12:8] <= 5'h10 && hrdata[4:0] <= 5'h10)
    else $error("count above depth");
  tx_clear_a: assert property (rn && sh[`UFC_BIT_TXCLR] && $past(sh[`UFC_BIT_TXCLR])
    |=> hrdata[12:8] == 5'h0) else $error("tx count kept under clear");
  rx_clear_a: assert property (rn && sh[`UFC_BIT_RXCLR] && $past(sh[`UFC_BIT_RXCLR])
    |=> hrdata[4:0] == 5'h0) else $error("rx count kept under clear");
  data_hold_a: assert property (!rp |=> $stable(hrdata))
    else $error("read data moved without a read");
  irq_mask_a: assert property (irq |-> en != 2'h0)
    else $error("irq with all sources masked");
endmodule // ufc_fifo_monitor

bind ufc_fifo_control ufc_fifo_monitor mon_u (.clk(clk), .rst_n(rst_n), .standby(standby),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txd(txd),
  .rts_n(rts_n), .irq(irq));

// >>> ufc_remote.sv
// Purpose: remote serial device model
// Assumes: 8n1 frames at clk/32 per bit
// Notes: line idles high, as a pulled-up wire would
module ufc_remote #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic sck_in
);
  // ********************
  // line and clock
  // ********************
  logic [1:0] ph = 2'h0;
  // quarter of clk: the fastest external clock allowed
  always @(posedge clk) ph <= ph + 2'h1;
  assign sck_in = ph[1];
  initial rxd = 1'b1;
  // one frame, lsb first; the line moves only on a rising edge
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
  // one frame from the block, sampled at bit centres; the bench timeout ends a hang
  task automatic recv(output logic [7:0] b, output logic stop);
    while (txd !== 1'b0) @(posedge clk);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      b[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge clk);
    stop = txd;
  endtask
endmodule // ufc_remote

// >>> tb_top.sv
// Purpose: self-checking bench of the fifo control block
// Assumes: zero-wait bus, reset baud gives 32 clocks a bit
// Notes: scenarios run in order and share fifo state
`include "ufc_defines.vh"
`define UFC_CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, standby = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic cts_n = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire [31:0] hrdata;
  wire hready, hresp, txd, rts_n, irq, rxd, sck_in;
  int n_fail = 0, checked = 0, cyc = 0;
  always #10 clk = ~clk;
  ufc_fifo_control dut_u (.clk(clk), .rst_n(rst_n), .standby(standby), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .txd(txd),
    .rxd(rxd), .cts_n(cts_n), .rts_n(rts_n), .sck_in(sck_in), .irq(irq));
  ufc_remote rem_u (.clk(clk), .txd(txd), .rxd(rxd), .sck_in(sck_in));
  // ********************
  // bus tasks
  // ********************
  // single transfer; ends just past the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e, input string nm);
    bus(1'b0, a, 32'h0);
    `UFC_CHK(nm, e, rd & m)
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_ctrl;
    bus(1'b1, `UFC_OFS_CTRL, 32'hf8);
    rdchk(`UFC_OFS_CTRL, 32'hff, 32'hf8, "ctrl rw");
    bus(1'b1, `UFC_OFS_COUNT, 32'hffff);
    bus(1'b1, 8'h40, 32'hffff);
    rdchk(`UFC_OFS_COUNT, 32'hffffffff, 32'h0, "count ro");
    rdchk(8'h40, 32'hffffffff, 32'h0, "unmapped");
    bus(1'b1, `UFC_OFS_CTRL, 32'h0);
  endtask
  // far side stalls with cts high, so the fifo fills
  task automatic t_tx;
    @(posedge clk);
    cts_n <= 1'b1;
    bus(1'b1, `UFC_OFS_CTRL, 32'h08);
    for (int i = 0; i < 17; i++) bus(1'b1, `UFC_OFS_TXDATA, i);
    rdchk(`UFC_OFS_COUNT, 32'h1f1f, 32'h1000, "tx full");
    `UFC_CHK("txd stalled", 1'b1, txd)
    rdchk(`UFC_OFS_IRQ_STAT, 32'h200, 32'h0, "tx low at 16");
    bus(1'b1, `UFC_OFS_CTRL, 32'h3c);
    rdchk(`UFC_OFS_COUNT, 32'h1f00, 32'h0, "tx cleared");
    rdchk(`UFC_OFS_IRQ_STAT, 32'h200, 32'h200, "tx low at 0");
    bus(1'b1, `UFC_OFS_CTRL, 32'h0);
    @(posedge clk);
    cts_n <= 1'b0;
  endtask
  task automatic t_rx;
    rem_u.send(8'ha5);
    rem_u.send(8'h3c);
    repeat (8) @(posedge clk);
    rdchk(`UFC_OFS_COUNT, 32'h1f1f, 32'h0002, "rx count");
    rdchk(`UFC_OFS_IRQ_STAT, 32'h100, 32'h100, "rx over 1");
    bus(1'b1, `UFC_OFS_CTRL, 32'h40);
    rdchk(`UFC_OFS_IRQ_STAT, 32'h100, 32'h0, "rx under 4");
    rdchk(`UFC_OFS_RXDATA, 32'hff, 32'ha5, "rx first");
    rdchk(`UFC_OFS_COUNT, 32'h1f, 32'h1, "rx popped");
    bus(1'b1, `UFC_OFS_CTRL, 32'h42);
    rdchk(`UFC_OFS_COUNT, 32'h1f, 32'h0, "rx cleared");
    bus(1'b1, `UFC_OFS_CTRL, 32'h0);
  endtask
  // the far side talks meanwhile; only the looped byte may arrive
  task automatic t_loop;
    bus(1'b1, `UFC_OFS_CTRL, 32'h01);
    bus(1'b1, `UFC_OFS_TXDATA, 32'h5a);
    rem_u.send(8'h00);
    repeat (80) @(posedge clk);
    rdchk(`UFC_OFS_COUNT, 32'h1f1f, 32'h1, "loop count");
    rdchk(`UFC_OFS_RXDATA, 32'hff, 32'h5a, "loop data");
    bus(1'b1, `UFC_OFS_CTRL, 32'h0);
  endtask
  // cts held high with modem control off must not stall the line
  task automatic t_line;
    logic [7:0] b;
    logic sb;
    @(posedge clk);
    cts_n <= 1'b1;
    bus(1'b1, `UFC_OFS_TXDATA, 32'hc3);
    `UFC_CHK("rts off", 1'b0, rts_n)
    rem_u.recv(b, sb);
    `UFC_CHK("txd byte", 8'hc3, b)
    `UFC_CHK("txd stop", 1'b1, sb)
    repeat (32) @(posedge clk);
    cts_n <= 1'b0;
  endtask
  // external 16x clock at clk/4 doubles the frame time over the reset divisor
  task automatic t_ext;
    rdchk(`UFC_OFS_BAUD, 32'h7ff, 32'h0, "baud reset");
    bus(1'b1, `UFC_OFS_BAUD, 32'h400);
    rdchk(`UFC_OFS_BAUD, 32'h7ff, 32'h400, "baud ext");
    bus(1'b1, `UFC_OFS_CTRL, 32'h01);
    bus(1'b1, `UFC_OFS_TXDATA, 32'h96);
    repeat (400) @(posedge clk);
    rdchk(`UFC_OFS_COUNT, 32'h1f, 32'h0, "ext not yet");
    repeat (300) @(posedge clk);
    rdchk(`UFC_OFS_RXDATA, 32'hff, 32'h96, "ext loop data");
    bus(1'b1, `UFC_OFS_CTRL, 32'h0);
    bus(1'b1, `UFC_OFS_BAUD, 32'h0);
  endtask
  task automatic t_irq;
    bus(1'b1, `UFC_OFS_IRQ_EN, 32'h2);
    `UFC_CHK("irq tx low", 1'b1, irq)
    bus(1'b1, `UFC_OFS_IRQ_CLR, 32'h2);
    `UFC_CHK("irq set wins", 1'b1, irq)
    bus(1'b1, `UFC_OFS_IRQ_EN, 32'h0);
    `UFC_CHK("irq masked", 1'b0, irq)
    bus(1'b1, `UFC_OFS_IRQ_EN, 32'h1);
    `UFC_CHK("irq rx sticky", 1'b1, irq)
    bus(1'b1, `UFC_OFS_IRQ_CLR, 32'h1);
    `UFC_CHK("irq cleared", 1'b0, irq)
  endtask
  task automatic t_stby;
    @(posedge clk);
    cts_n <= 1'b1;
    bus(1'b1, `UFC_OFS_CTRL, 32'hcb);
    bus(1'b1, `UFC_OFS_TXDATA, 32'h11);
    bus(1'b1, `UFC_OFS_CTRL, 32'h08);
    bus(1'b1, `UFC_OFS_TXDATA, 32'h22);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rdchk(`UFC_OFS_CTRL, 32'hff, 32'h0, "ctrl standby");
    rdchk(`UFC_OFS_COUNT, 32'hffffffff, 32'h0, "fifos standby");
    @(posedge clk);
    cts_n <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, well above the few thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`UFC_OFS_CTRL, 32'hff, 32'h0, "ctrl reset");
    rdchk(`UFC_OFS_COUNT, 32'hffffffff, 32'h0, "count reset");
    t_ctrl();
    t_tx();
    t_rx();
    t_loop();
    t_line();
    t_ext();
    t_irq();
    t_stby();
    complete_run();
  end
endmodule // tb_top
